// >>> verilog/mscr_pkg.sv
package mscr_pkg;
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 32;
    localparam int          SPEED_W         = 15;
    localparam logic [11:0] OFF_CTRL        = 12'h0E8;
    localparam logic [11:0] OFF_CMD_DUTY    = 12'h40C;
    localparam logic [11:0] OFF_APPLIED     = 12'h4F6;
    localparam logic [11:0] OFF_TARGET      = 12'h506;
    localparam logic [11:0] OFF_SPEED_PU    = 12'h5B2;
    localparam logic [11:0] OFF_POWER_PU    = 12'h6F4;
    localparam int          SPEED_LSB       = 16;
    localparam int          SPEED_MSB       = 30;
    localparam int          SELECT_BIT      = 15;
    localparam int          TOP_BIT         = 31;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
    localparam logic [31:0] RO_RESET        = 32'h0000_0000;
    localparam logic [31:0] CTRL_WR_MASK    = 32'hFFFF_8000;
    localparam logic [14:0] SPEED_FULL      = 15'h7FFF;
    localparam logic [31:0] DUTY_ONE        = 32'h4000_0000;
    localparam int          MAX_SPEED_DIV   = 16;
endpackage : mscr_pkg

// >>> verilog/mscr_speed_select.sv
`timescale 1ns/1ps
module mscr_speed_select (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        useDigital,
    input  wire logic [14:0] digitalSpeed,
    input  wire logic [14:0] pinSpeed,
    output logic      [14:0] speedCmd
);
    logic [14:0] speedCmd_r;
    logic [14:0] speedCmd_nxt;

    always_comb begin
        speedCmd_nxt = useDigital ? digitalSpeed : pinSpeed;  // [RULE2] [RULE3]
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            speedCmd_r <= 15'h0000;
        end else begin
            speedCmd_r <= speedCmd_nxt;
        end
    end

    assign speedCmd = speedCmd_r;
endmodule : mscr_speed_select

// >>> verilog/mscr_regs.sv
`timescale 1ns/1ps
// How it works
// (RULE1) 15-bit digital speed in bits 30..16
// (RULE2) Select zero: speed from pin input
// (RULE3) Select one: speed from digital field
// (RULE4) Control at E8h, low bits read zero
// (RULE5) Host never writes unlisted offsets
// (RULE6) Commanded duty readout at 40Ch
// (RULE7) Applied duty readout at 4F6h
// (RULE8) Target duty readout at 506h
// (RULE9) Speed per unit at 5B2h, reset zero
// (RULE10) Speed scaled by max speed over 16; the code passes speedPuIn through unscaled
// (RULE11) Writes to read-only registers ignored
module mscr_regs (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic [11:0] regAddr,
    input  wire logic [31:0] regWdata,
    output logic      [31:0] regRdata,
    output logic             regRvalid,
    input  wire logic [14:0] pinSpeed,
    input  wire logic [31:0] cmdDutyIn,
    input  wire logic [31:0] appliedDutyIn,
    input  wire logic [31:0] targetDutyIn,
    input  wire logic [31:0] speedPuIn,
    input  wire logic [31:0] powerPuIn,
    output logic [14:0]      speedCmd,
    output logic             digitalSelected
);
    logic [31:0] ctrl_r;
    logic [31:0] ctrl_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic        rvalid_r;
    logic        rvalid_nxt;
    logic [31:0] cmdDuty_r;
    logic [31:0] cmdDuty_nxt;
    logic [31:0] applied_r;
    logic [31:0] applied_nxt;
    logic [31:0] target_r;
    logic [31:0] target_nxt;
    logic [31:0] speedPu_r;
    logic [31:0] speedPu_nxt;
    logic [31:0] powerPu_r;
    logic [31:0] powerPu_nxt;
    logic [14:0] speedSel;
    logic        ctrlHit;
    logic        ctrlWrite;
    logic        useDigital;
    logic [14:0] digitalSpeed;

    // True when the offset names the control word
    function automatic logic addrIsCtrl(input logic [11:0] addr);
        return (addr == mscr_pkg::OFF_CTRL);
    endfunction : addrIsCtrl

    // True when the offset names one of the read-only readouts
    function automatic logic addrIsReadout(input logic [11:0] addr);
        logic hit;
        hit = 1'b0;
        if (addr == mscr_pkg::OFF_CMD_DUTY) begin
            hit = 1'b1;
        end else if (addr == mscr_pkg::OFF_APPLIED) begin
            hit = 1'b1;
        end else if (addr == mscr_pkg::OFF_TARGET) begin
            hit = 1'b1;
        end else if (addr == mscr_pkg::OFF_SPEED_PU) begin
            hit = 1'b1;
        end else if (addr == mscr_pkg::OFF_POWER_PU) begin
            hit = 1'b1;
        end
        return hit;
    endfunction : addrIsReadout

    // Keeps only the writable fields of the control word
    function automatic logic [31:0] ctrlKeep(input logic [31:0] word);
        return word & mscr_pkg::CTRL_WR_MASK;
    endfunction : ctrlKeep

    // Picks the readout named by the offset, zero otherwise
    function automatic logic [31:0] readoutValue(
        input logic [11:0] addr,
        input logic [31:0] cmdDuty,
        input logic [31:0] applied,
        input logic [31:0] target,
        input logic [31:0] speedPu,
        input logic [31:0] powerPu
    );
        logic [31:0] value;
        value = 32'h0000_0000;
        if (addr == mscr_pkg::OFF_CMD_DUTY) begin
            value = cmdDuty;  // [RULE6]
        end else if (addr == mscr_pkg::OFF_APPLIED) begin
            value = applied;  // [RULE7]
        end else if (addr == mscr_pkg::OFF_TARGET) begin
            value = target;  // [RULE8]
        end else if (addr == mscr_pkg::OFF_SPEED_PU) begin
            value = speedPu;  // [RULE9]
        end else if (addr == mscr_pkg::OFF_POWER_PU) begin
            value = powerPu;
        end
        return value;
    endfunction : readoutValue

    // Telemetry follows the algorithm; the port has no path into it
    always_comb begin
        cmdDuty_nxt = cmdDutyIn;      // [RULE6]
        applied_nxt = appliedDutyIn;  // [RULE7]
        target_nxt  = targetDutyIn;   // [RULE8]
        speedPu_nxt = speedPuIn;      // [RULE9] [RULE10]
        powerPu_nxt = powerPuIn;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cmdDuty_r <= mscr_pkg::RO_RESET;
            applied_r <= mscr_pkg::RO_RESET;
            target_r  <= mscr_pkg::RO_RESET;
            speedPu_r <= mscr_pkg::RO_RESET;  // [RULE9]
            powerPu_r <= mscr_pkg::RO_RESET;
        end else begin
            cmdDuty_r <= cmdDuty_nxt;
            applied_r <= applied_nxt;
            target_r  <= target_nxt;
            speedPu_r <= speedPu_nxt;
            powerPu_r <= powerPu_nxt;
        end
    end

    // Offset decode shared by the write and read paths
    always_comb begin
        ctrlHit   = addrIsCtrl(regAddr);
        ctrlWrite = regWrite && ctrlHit;
    end

    // Control word write path
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (ctrlWrite) begin
            ctrl_nxt = ctrlKeep(regWdata);  // [RULE1] [RULE4]
        end
        // Other offsets, read-only ones included, are dropped  [RULE11]
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_r <= mscr_pkg::CTRL_RESET;  // [RULE4]
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // Read path: data held until the next read, valid for one cycle
    always_comb begin
        rdata_nxt  = rdata_r;
        rvalid_nxt = 1'b0;
        if (regRead) begin
            rvalid_nxt = 1'b1;
            if (ctrlHit) begin
                rdata_nxt = ctrlKeep(ctrl_r);  // [RULE4]
            end else if (addrIsReadout(regAddr)) begin
                rdata_nxt = readoutValue(regAddr, cmdDuty_r, applied_r, target_r, speedPu_r, powerPu_r);
            end else begin
                rdata_nxt = 32'h0000_0000;  // [RULE5]
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r  <= 32'h0000_0000;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // Fields handed to the source selector
    always_comb begin
        useDigital   = ctrl_r[mscr_pkg::SELECT_BIT];                   // [RULE2] [RULE3]
        digitalSpeed = ctrl_r[mscr_pkg::SPEED_MSB:mscr_pkg::SPEED_LSB];  // [RULE1]
    end

    mscr_speed_select u_sel (
        .clock        (clock),
        .arst_n       (arst_n),
        .useDigital   (useDigital),
        .digitalSpeed (digitalSpeed),
        .pinSpeed     (pinSpeed),
        .speedCmd     (speedSel)
    );

    // All outputs come straight from registers
    assign regRdata        = rdata_r;
    assign regRvalid       = rvalid_r;
    assign speedCmd        = speedSel;
    assign digitalSelected = ctrl_r[mscr_pkg::SELECT_BIT];  // [RULE3]
endmodule : mscr_regs

// >>> testbench/mscr_regs_assertions.sv
`timescale 1ns/1ps
module mscr_regs_assertions (
    input wire logic        clock, arst_n, regWrite, regRead, regRvalid, digitalSelected,
    input wire logic [11:0] regAddr,
    input wire logic [31:0] regWdata, regRdata, cmdDutyIn, speedPuIn,
    input wire logic [14:0] pinSpeed, speedCmd
);
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    wire ctrlWr = regWrite && regAddr == 12'h0E8;
    AST_RVALID: assert property (regRead |=> regRvalid) else $error("no read valid");
    AST_NO_RVALID: assert property (!regRead |=> !regRvalid) else $error("stray valid");
    AST_SEL: assert property (ctrlWr |=> digitalSelected == $past(regWdata[15])) else $error("select");
    AST_SEL_HOLD: assert property (!ctrlWr |=> $stable(digitalSelected)) else $error("select moved");
    AST_PIN: assert property (!digitalSelected |=> speedCmd == $past(pinSpeed)) else $error("pin speed");
    AST_DIG: assert property (ctrlWr && regWdata[15] ##1 1
        |=> speedCmd == $past(regWdata[30:16], 2)) else $error("digital speed");
    AST_CMD_DUTY: assert property ($past(arst_n) && regRead && regAddr == 12'h40C
        |=> regRdata == $past(cmdDutyIn, 2)) else $error("commanded duty");
    AST_SPEED_PU: assert property ($past(arst_n) && regRead && regAddr == 12'h5B2
        |=> regRdata == $past(speedPuIn, 2)) else $error("speed");
endmodule : mscr_regs_assertions

bind mscr_regs mscr_regs_assertions chk (.*);

// >>> testbench/mscr_host_model.sv
`timescale 1ns/1ps
module mscr_host_model (
    input  wire logic        clock,
    input  wire logic        regRvalid,
    input  wire logic [31:0] regRdata,
    output logic             regWrite, regRead,
    output logic      [11:0] regAddr,
    output logic      [31:0] regWdata
);
    initial {regWrite, regRead, regAddr, regWdata} = '0;
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clock);
        {regWrite, regRead, regAddr, regWdata} <= {w, !w, a, d};
        @(posedge clock);
        // Released lines do not keep the last value
        {regWrite, regRead, regAddr, regWdata} <= {2'b00, ~a, ~d};
        q = 32'h0;
        if (!w) begin
            @(negedge clock);
            q = regRvalid ? regRdata : 32'hDEAD_BEEF;
        end
    endtask : xfer
endmodule : mscr_host_model

// >>> testbench/mscr_regs_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module mscr_regs_bench;
    logic        clock = 0, arst_n = 0, regWrite, regRead, regRvalid, digitalSelected;
    logic [11:0] regAddr;
    logic [14:0] pinSpeed = 15'h1234, speedCmd;
    logic [31:0] regWdata, regRdata, q, cmdDutyIn = 32'h4000_0000, appliedDutyIn = 32'h2000_0000;
    logic [31:0] targetDutyIn = 32'h1000_0001, speedPuIn = 32'h8000_0000, powerPuIn = 32'h0000_00FF;
    logic [43:0] rows [8] = '{{12'h0E8, 32'h0}, {12'h40C, 32'h4000_0000}, {12'h4F6, 32'h2000_0000},
        {12'h506, 32'h1000_0001}, {12'h5B2, 32'h8000_0000}, {12'h6F4, 32'h0000_00FF}, {12'h000, 32'h0}, {12'h0EC, 32'h0}};
    int bad_count = 0, n_tests = 0;
    mscr_regs uut (.*);
    mscr_host_model host (.*);
    initial forever #5 clock = ~clock;
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (12) @(posedge clock);
        arst_n <= 1;
        for (int i = 1; i < 6; i++) host.xfer(1, rows[i][43:32], 32'hFFFF_FFFF, q);
        foreach (rows[i]) begin
            host.xfer(0, rows[i][43:32], 0, q);
            `CHK("readout", rows[i][31:0], q)
        end
        host.xfer(1, 12'h0E8, 32'h7FFF_0000, q);
        pinSpeed <= 15'h4321;
        repeat (2) @(negedge clock);
        `CHK("pin speed", 15'h4321, speedCmd)
        host.xfer(1, 12'h0E8, 32'hFFFF_FFFF, q);
        host.xfer(0, 12'h0E8, 0, q);
        `CHK("control", 32'hFFFF_8000, q)
        `CHK("digital speed", 15'h7FFF, speedCmd)
        `CHK("select", 1'b1, digitalSelected)
        @(posedge clock);
        arst_n <= 0;
        @(negedge clock);
        `CHK("reset outputs", 48'h0, {regRdata, digitalSelected, speedCmd})
        @(posedge clock);
        arst_n <= 1;
        host.xfer(0, 12'h0E8, 0, q);
        `CHK("control reset", 32'h0, q)
        end_of_test();
    end
endmodule : mscr_regs_bench
